//--- core/angle_injection_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants for the crank-angle injection sequencer
// Assumes: angles in tenths of a crank degree, durations in microseconds
// Notes:   one engine cycle spans two revolutions
//////////////////////////////////////////////////////////////////////////////
package angle_injection_pkg;

  // sequence shape
  localparam int unsigned SLOTS     = 6;      // pulse slots per cycle
  localparam int unsigned CHANS     = 3;      // channels per driver module

  // angle scale, tenths of a degree
  localparam int unsigned ANG_W     = 13;     // absolute crank angle width
  localparam int          ANG_FULL  = 7200;   // 720.0 degrees per engine cycle
  localparam int unsigned SANG_W    = 16;     // signed programmed angle width

  // duration scale
  localparam int unsigned DUR_W     = 16;     // duration in microseconds
  localparam int unsigned RPM_W     = 14;     // engine speed in rev/min
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned US_PER_S  = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S; // 20 clocks per microsecond
  localparam int unsigned REM_W     = 21;     // holds max duration in clocks

  // duration-to-angle: us * rpm * 6 / 100000 gives tenths of a degree
  localparam int unsigned DA_NUM    = 6;
  localparam int unsigned DA_DEN    = 100_000;
  localparam int unsigned DA_PROD_W = 40;

  // skip-fire counters
  localparam int unsigned SKIP_W    = 8;

  // reset values
  localparam logic [SANG_W-1:0] ANGLE_RST = 16'h0000;
  localparam logic [SKIP_W-1:0] SKIP_RST  = 8'h00;

endpackage : angle_injection_pkg

//--- core/angle_injection_sequencer.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: angle-placed multi-pulse injection commands for one driver module
// Assumes: crank angle, speed, cycle start and top references are synchronous
// Notes:   all state lives in one packed struct registered once per clock
//          a pulse rises one clock after the crank sample that passes its angle
//          and then lasts its duration in clocks, whatever the crank speed
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none

module angle_injection_sequencer
  import angle_injection_pkg::*;
#(
  parameter int unsigned NSLOT = SLOTS,       // pulse slots
  parameter int unsigned NCH   = CHANS        // channels
) (
  input  wire logic                              i_clk,                // system clock
  input  wire logic                              i_resetn,             // async reset, low
  input  wire logic                              i_angle_tracked_mode, // angle mode enable
  input  wire logic                              i_placement_select,   // 0 start, 1 end
  input  wire logic [NSLOT-1:0]                  i_pulse_enable,       // slot enables
  input  wire logic                              i_angle_wr,           // angle write strobe
  input  wire logic                              i_angle_wr_end,       // 1 end set, 0 start
  input  wire logic [2:0]                        i_angle_wr_slot,      // slot index
  input  wire logic signed [SANG_W-1:0]          i_angle_wr_data,      // degrees_before_top
  output logic                                   o_angle_wr_rejected,  // reject pulse
  output logic signed [NSLOT-1:0][SANG_W-1:0]    o_start_angle,        // start set readback
  output logic signed [NSLOT-1:0][SANG_W-1:0]    o_end_angle,          // end set readback
  input  wire logic                              i_per_channel_dur,    // per-channel mode
  input  wire logic [NSLOT-1:0][DUR_W-1:0]       i_uniform_dur_us,     // module durations
  input  wire logic [NCH-1:0][NSLOT-1:0][DUR_W-1:0] i_channel_dur_us,  // channel durations
  output logic                                   o_per_channel_status, // mode indicator
  input  wire logic [SKIP_W-1:0]                 i_skip_period_length, // cycles per period
  input  wire logic [SKIP_W-1:0]                 i_skip_active_count,  // firing cycles
  input  wire logic [NCH-1:0]                    i_channel_skip_enable,// skip per channel
  input  wire logic [ANG_W-1:0]                  i_crank_angle,        // crank_angle_degrees
  input  wire logic [RPM_W-1:0]                  i_engine_rpm,         // engine speed
  input  wire logic                              i_cycle_start,        // cycle boundary
  input  wire logic [NCH-1:0][ANG_W-1:0]         i_piston_top_reference, // top per channel
  output logic [NCH-1:0]                         o_inject_cmd,         // injector commands
  output logic [NCH-1:0]                         o_fire_this_cycle,    // skip decision
  output logic [NCH-1:0][NSLOT-1:0][DUR_W-1:0]   o_dur_angle           // duration in angle
);

  // everything the block remembers, registered as one word
  typedef struct packed {
    logic signed [NSLOT-1:0][SANG_W-1:0]  start_ang;
    logic signed [NSLOT-1:0][SANG_W-1:0]  end_ang;
    logic [ANG_W-1:0]                     prev_angle;
    logic                                 angle_valid;
    logic                                 skip_started;
    logic [SKIP_W-1:0]                    skip_pos;
    logic [NCH-1:0]                       fire;
    logic [NCH-1:0][NSLOT-1:0][REM_W-1:0] remain;
    logic [NCH-1:0][NSLOT-1:0][DUR_W-1:0] dur_angle;
    logic [NCH-1:0]                       cmd;
    logic                                 reject;
    logic                                 status;
  } state_s;

  // present state and the value it takes at the next edge
  state_s st_reg;
  state_s st_next;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // wrap a signed angle into one engine cycle
  function automatic logic [ANG_W-1:0] wrap_angle(input int v);
    int m;
    m = v % ANG_FULL;
    if (m < 0) begin
      m = m + ANG_FULL;
    end
    return ANG_W'(m);
  endfunction : wrap_angle

  // target passed between last and current sample, wrap aware
  // a standing crank crosses nothing, a wrap covers both ends of the cycle
  function automatic logic crossed(input logic [ANG_W-1:0] p,
                                   input logic [ANG_W-1:0] c,
                                   input logic [ANG_W-1:0] t);
    logic r;
    r = 1'b0;
    if (p < c) begin
      r = (t > p) && (t <= c);
    end else if (p > c) begin
      r = (t > p) || (t <= c);
    end
    return r;
  endfunction : crossed

  // time to crank angle in tenths of a degree, saturating
  // wide product, so high speed saturates the readback instead of wrapping
  function automatic logic [DUR_W-1:0] dur_to_angle(input logic [DUR_W-1:0] us,
                                                    input logic [RPM_W-1:0] rpm);
    logic [DA_PROD_W-1:0] p;
    p = DA_PROD_W'(us) * DA_PROD_W'(rpm) * DA_PROD_W'(DA_NUM);
    p = p / DA_PROD_W'(DA_DEN);
    if (p > DA_PROD_W'({DUR_W{1'b1}})) begin
      p = DA_PROD_W'({DUR_W{1'b1}});
    end
    return p[DUR_W-1:0];
  endfunction : dur_to_angle

  // raise a zero skip count to one, both counts have a floor of one cycle
  function automatic logic [SKIP_W-1:0] at_least_one(input logic [SKIP_W-1:0] v);
    logic [SKIP_W-1:0] r;
    r = v;
    if (v == SKIP_RST) begin
      r = SKIP_W'(1);
    end
    return r;
  endfunction : at_least_one

  // microseconds for one slot of one channel, own list only in per-channel mode
  function automatic logic [DUR_W-1:0] slot_duration(input logic             per_chan,
                                                     input logic [DUR_W-1:0] own,
                                                     input logic [DUR_W-1:0] shared);
    logic [DUR_W-1:0] d;
    d = per_chan ? own : shared;
    return d;
  endfunction : slot_duration

  // crank angle at which a slot starts; the lead moves an end angle back by
  // the pulse length in angle; an element select of a packed angle set has no
  // sign, so it is put back before the subtraction or late angles land wrong
  function automatic logic [ANG_W-1:0] slot_target(input logic [ANG_W-1:0]  top,
                                                   input logic [SANG_W-1:0] ang,
                                                   input logic [DUR_W-1:0]  lead);
    int v;
    v = int'(top) - int'($signed(ang)) - int'(lead);
    return wrap_angle(v);
  endfunction : slot_target

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  // one pass over the whole state; every field keeps its value unless set
  always_comb begin
    logic [SKIP_W-1:0]    period;
    logic [SKIP_W-1:0]    active;
    logic [SKIP_W-1:0]    pos;
    logic [DUR_W-1:0]     dur;
    logic [ANG_W-1:0]     target;
    logic [ANG_W-1:0]     top;
    logic                 hit;
    period  = SKIP_RST;
    active  = SKIP_RST;
    pos     = SKIP_RST;
    dur     = '0;
    target  = '0;
    top     = '0;
    hit     = 1'b0;
    st_next = st_reg;
    st_next.reject = 1'b0;
    st_next.status = i_per_channel_dur;

    // angle writes only land in the set the current mode uses
    // a slot beyond the sequence is refused the same way
    if (i_angle_wr) begin
      if (i_angle_wr_slot >= 3'(NSLOT)) begin
        st_next.reject = 1'b1;
      end else if (i_angle_wr_end != i_placement_select) begin
        st_next.reject = 1'b1;
      end else if (i_angle_wr_end) begin
        st_next.end_ang[i_angle_wr_slot] = i_angle_wr_data;
      end else begin
        st_next.start_ang[i_angle_wr_slot] = i_angle_wr_data;
      end
    end

    // skip pattern: clamp period and active count to at least one
    period = at_least_one(i_skip_period_length);
    active = at_least_one(i_skip_active_count);
    // an active count above the period fires on every cycle
    if (active > period) begin
      active = period;
    end
    // one position for all channels; turning skip on does not restart it
    if (i_cycle_start) begin
      pos = SKIP_RST;
      if (st_reg.skip_started && (st_reg.skip_pos + SKIP_W'(1) < period)) begin
        pos = st_reg.skip_pos + SKIP_W'(1);
      end
      st_next.skip_pos     = pos;
      st_next.skip_started = 1'b1;
      for (int c = 0; c < NCH; c++) begin
        st_next.fire[c] = !(i_angle_tracked_mode && i_channel_skip_enable[c])
                          || (pos < active);
      end
    end

    // crank samples
    // the previous sample and the current one bound each crossing test
    st_next.prev_angle  = i_crank_angle;
    st_next.angle_valid = 1'b1;

    // angle equivalent of every duration, refreshed each clock for readback
    // a slow speed input moves the readback and the end-placed start angles, never a running pulse
    for (int c = 0; c < NCH; c++) begin
      for (int s = 0; s < NSLOT; s++) begin
        dur = slot_duration(i_per_channel_dur, i_channel_dur_us[c][s],
                            i_uniform_dur_us[s]);
        st_next.dur_angle[c][s] = dur_to_angle(dur, i_engine_rpm);
      end
    end

    // per channel and slot: start angle and timers; end placement takes the
    // registered angle equivalent, which trails the speed input by one clock
    for (int c = 0; c < NCH; c++) begin
      top = i_piston_top_reference[c];
      for (int s = 0; s < NSLOT; s++) begin
        dur = slot_duration(i_per_channel_dur, i_channel_dur_us[c][s],
                            i_uniform_dur_us[s]);
        // angles are module-wide, the top reference and the duration belong to the channel
        if (i_placement_select) begin
          target = slot_target(top, st_reg.end_ang[s], st_reg.dur_angle[c][s]);
        end else begin
          target = slot_target(top, st_reg.start_ang[s], DUR_W'(0));
        end
        // the first sample after reset only arms the crossing test
        hit = st_reg.angle_valid && i_angle_tracked_mode
              && crossed(st_reg.prev_angle, i_crank_angle, target);
        // a skipped cycle or zero duration starts nothing; a restart reloads
        if (hit && st_next.fire[c] && (dur != '0)) begin
          st_next.remain[c][s] = REM_W'(dur) * REM_W'(CYC_PER_US);
        end else if (st_reg.remain[c][s] != '0) begin
          st_next.remain[c][s] = st_reg.remain[c][s] - REM_W'(1);
        end
      end
    end

    // command follows running timers of enabled slots only
    // a disabled slot still counts down, so the other slots keep their places
    for (int c = 0; c < NCH; c++) begin
      st_next.cmd[c] = 1'b0;
      for (int s = 0; s < NSLOT; s++) begin
        if ((st_next.remain[c][s] != '0) && i_pulse_enable[s]) begin
          st_next.cmd[c] = 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  // reset lets every channel fire until the first cycle boundary is seen
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg.start_ang    <= {NSLOT{ANGLE_RST}};
      st_reg.end_ang      <= {NSLOT{ANGLE_RST}};
      st_reg.prev_angle   <= '0;
      st_reg.angle_valid  <= 1'b0;
      st_reg.skip_started <= 1'b0;
      st_reg.skip_pos     <= SKIP_RST;
      st_reg.fire         <= '1;
      st_reg.remain       <= '0;
      st_reg.dur_angle    <= '0;
      st_reg.cmd          <= '0;
      st_reg.reject       <= 1'b0;
      st_reg.status       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from the state register
  // status and reject trail the inputs that cause them by one clock
  assign o_inject_cmd         = st_reg.cmd;
  assign o_fire_this_cycle    = st_reg.fire;
  assign o_dur_angle          = st_reg.dur_angle;
  assign o_per_channel_status = st_reg.status;
  assign o_angle_wr_rejected  = st_reg.reject;
  assign o_start_angle        = st_reg.start_ang;
  assign o_end_angle          = st_reg.end_ang;

endmodule : angle_injection_sequencer

`default_nettype wire

//--- tb/crank_source.sv
// Purpose: engine position source model for the sequencer bench
// Assumes: crank advances one degree (ten tenths) per clock
// Notes:   cycle start pulses as the angle wraps to zero
`timescale 1ns/1ps
`default_nettype none
module crank_source
  import angle_injection_pkg::*;
(
  input  wire logic        i_clk,    // system clock
  input  wire logic        i_resetn, // async reset, low
  output logic [ANG_W-1:0] o_angle,  // crank angle
  output logic             o_cycle   // cycle boundary pulse
);
  // advance angle and mark the wrap, changing just after the falling edge
  always @(negedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_angle <= '0;
      o_cycle <= 1'b0;
    end else begin
      o_cycle <= (o_angle == ANG_W'(ANG_FULL - 10));
      o_angle <= (o_angle == ANG_W'(ANG_FULL - 10)) ? '0 : o_angle + 13'h000A;
    end
  end
endmodule : crank_source
`default_nettype wire

//--- tb/angle_injection_sequencer_assertions.sv
// Purpose: port-level checks of the injection sequencer
// Assumes: single clock domain, async active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module angle_injection_sequencer_assertions
  import angle_injection_pkg::*;
#(
  parameter int unsigned NSLOT = SLOTS, // pulse slots
  parameter int unsigned NCH   = CHANS  // channels
) (
  input wire logic                           i_clk,                // clock
  input wire logic                           i_resetn,             // reset, low
  input wire logic                           i_angle_tracked_mode, // angle mode
  input wire logic                           i_placement_select,   // mode select
  input wire logic                           i_angle_wr,           // write strobe
  input wire logic                           i_angle_wr_end,       // set select
  input wire logic [2:0]                     i_angle_wr_slot,      // slot index
  input wire logic signed [SANG_W-1:0]       i_angle_wr_data,      // angle value
  input wire logic                           o_angle_wr_rejected,  // reject pulse
  input wire logic signed [NSLOT-1:0][SANG_W-1:0] o_start_angle,   // start set
  input wire logic signed [NSLOT-1:0][SANG_W-1:0] o_end_angle,     // end set
  input wire logic                           i_per_channel_dur,    // duration mode
  input wire logic                           o_per_channel_status, // mode indicator
  input wire logic                           i_cycle_start,        // cycle boundary
  input wire logic [NCH-1:0]                 o_fire_this_cycle,    // skip decision
  input wire logic [NCH-1:0]                 o_inject_cmd          // commands
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // write port, status, skip decision and command pulse width relations
  a_status_mirror: assert property ($past(i_resetn) |->
    o_per_channel_status == $past(i_per_channel_dur)) else $error("status not mirrored");
  a_reject_wrong_set: assert property (i_angle_wr && i_angle_wr_end != i_placement_select
    |=> o_angle_wr_rejected) else $error("write to idle set taken");
  a_hold_idle_set: assert property (i_angle_wr && i_angle_wr_end != i_placement_select
    |=> $stable(o_start_angle) && $stable(o_end_angle)) else $error("angle set changed");
  a_accept_write: assert property (i_angle_wr && i_angle_wr_end == i_placement_select
    && i_angle_wr_slot < 3'(NSLOT) |=> !o_angle_wr_rejected && ($past(i_angle_wr_end) ?
    o_end_angle[$past(i_angle_wr_slot)] : o_start_angle[$past(i_angle_wr_slot)])
    == $past(i_angle_wr_data)) else $error("angle write lost");
  a_reject_bad_slot: assert property (i_angle_wr && i_angle_wr_slot >= 3'(NSLOT)
    |=> o_angle_wr_rejected) else $error("slot above range taken");
  a_no_spurious_reject: assert property (!i_angle_wr |=> !o_angle_wr_rejected)
    else $error("reject without write");
  a_fire_when_off: assert property (i_cycle_start && !i_angle_tracked_mode
    |=> &o_fire_this_cycle) else $error("skip applied outside angle mode");
  a_fire_holds: assert property (!i_cycle_start |=> $stable(o_fire_this_cycle))
    else $error("skip decision moved within cycle");
  a_pulse_min_width: assert property ($rose(o_inject_cmd[0]) |-> o_inject_cmd[0][*8])
    else $error("command pulse too short");
endmodule : angle_injection_sequencer_assertions
bind angle_injection_sequencer angle_injection_sequencer_assertions #(.NSLOT(NSLOT), .NCH(NCH))
  u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_angle_tracked_mode(i_angle_tracked_mode),
  .i_placement_select(i_placement_select), .i_angle_wr(i_angle_wr),
  .i_angle_wr_end(i_angle_wr_end), .i_angle_wr_slot(i_angle_wr_slot),
  .i_angle_wr_data(i_angle_wr_data), .o_angle_wr_rejected(o_angle_wr_rejected),
  .o_start_angle(o_start_angle), .o_end_angle(o_end_angle),
  .i_per_channel_dur(i_per_channel_dur), .o_per_channel_status(o_per_channel_status),
  .i_cycle_start(i_cycle_start), .o_fire_this_cycle(o_fire_this_cycle),
  .o_inject_cmd(o_inject_cmd));
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the angle injection sequencer
// Assumes: 720 clocks per engine cycle, speed 10000 rev/min, all tops at 360.0
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  import angle_injection_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, mode = 1'b0, place = 1'b0, wr = 1'b0, wr_end = 1'b0, pcd = 1'b0;
  logic [2:0] slot = '0, skip_en = '0, cmd, fire, cmd_d = '0;
  logic signed [SANG_W-1:0] wdata = '0;
  logic [5:0] pen = 6'h01;
  logic [5:0][15:0] udur = '0;
  logic [2:0][5:0][15:0] cdur = '0, dang;
  logic [7:0] per = 8'h01, act = 8'h01;
  logic [12:0] crank, rise_ang, crank_d = '0;
  logic [2:0][12:0] top = {3{13'h0E10}};
  logic signed [5:0][15:0] sang, eang;
  logic cyc, rej, stat;
  int miscompares = 0, num_checks = 0, hi[3], rises[3];
  always #25 clk = ~clk;
  crank_source u_src (.i_clk(clk), .i_resetn(rstn), .o_angle(crank), .o_cycle(cyc));
  angle_injection_sequencer dut (
    .i_clk(clk), .i_resetn(rstn), .i_angle_tracked_mode(mode), .i_placement_select(place),
    .i_pulse_enable(pen), .i_angle_wr(wr), .i_angle_wr_end(wr_end), .i_angle_wr_slot(slot),
    .i_angle_wr_data(wdata), .o_angle_wr_rejected(rej), .o_start_angle(sang),
    .o_end_angle(eang), .i_per_channel_dur(pcd), .i_uniform_dur_us(udur),
    .i_channel_dur_us(cdur), .o_per_channel_status(stat), .i_skip_period_length(per),
    .i_skip_active_count(act), .i_channel_skip_enable(skip_en), .i_crank_angle(crank),
    .i_engine_rpm(14'h2710), .i_cycle_start(cyc), .i_piston_top_reference(top),
    .o_inject_cmd(cmd), .o_fire_this_cycle(fire), .o_dur_angle(dang));
  // count command high time, rises and the crank sample that launched a rise
  always @(posedge clk) begin
    for (int c = 0; c < 3; c++) begin
      hi[c] += cmd[c];
      if (cmd[c] && !cmd_d[c]) begin
        rises[c]++;
        rise_ang = crank_d;
      end
    end
    cmd_d <= cmd;
    crank_d <= crank;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk
  task automatic wr_angle(input logic e, input logic [2:0] s, input logic [15:0] d, input logic r);
    wr_end = e;
    slot = s;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    chk("reject", 32'(r), 32'(rej));
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_angle
  task automatic pulses(input string t, input int n, input int r[3], input int h[3]);
    @(posedge cyc);
    hi = '{0, 0, 0};
    rises = '{0, 0, 0};
    repeat (n) @(posedge cyc);
    for (int c = 0; c < 3; c++) begin
      chk($sformatf("%s rises %0d", t, c), r[c], rises[c]);
      chk($sformatf("%s high %0d", t, c), h[c], hi[c]);
    end
    $display("test %s done", t);
  endtask : pulses
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // watchdog well beyond the expected run of some 18000 clocks
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    chk("fire", 32'h7, 32'(fire));
    chk("status", 32'h0, 32'(stat));
    wr_angle(1'b0, 3'h0, 16'h012C, 1'b0);
    wr_angle(1'b0, 3'h5, 16'hFF38, 1'b0);
    chk("start5", 32'hFF38, 32'(sang[5]));
    wr_angle(1'b1, 3'h0, 16'h0122, 1'b1);
    chk("end0 kept", 32'h0, 32'(eang[0]));
    wr_angle(1'b0, 3'h6, 16'h0001, 1'b1);
    place = 1'b1;
    wr_angle(1'b1, 3'h0, 16'h0122, 1'b0);
    chk("end0", 32'h0122, 32'(eang[0]));
    chk("start0 kept", 32'h012C, 32'(sang[0]));
    wr_angle(1'b0, 3'h0, 16'h0005, 1'b1);
    $display("test angle writes done");
    udur[0] = 16'h01F4;
    cdur[2][0] = 16'h09C4;
    repeat (2) @(negedge clk);
    chk("dur angle 0", 32'd300, 32'(dang[0][0]));
    chk("dur angle 2 uniform", 32'd300, 32'(dang[2][0]));
    pcd = 1'b1;
    repeat (2) @(negedge clk);
    chk("dur angle 2 own", 32'd1500, 32'(dang[2][0]));
    chk("dur angle 0 own", 32'd0, 32'(dang[0][0]));
    chk("status", 32'h1, 32'(stat));
    $display("test duration angle done");
    udur[0] = 16'h0005;
    pcd = 1'b0;
    place = 1'b0;
    mode = 1'b1;
    pulses("start placement", 2, '{2, 2, 2}, '{200, 200, 200});
    chk("start rise angle", 32'h0CE4, 32'(rise_ang));
    place = 1'b1;
    pulses("end placement", 2, '{2, 2, 2}, '{200, 200, 200});
    chk("end rise angle", 32'h0CEE, 32'(rise_ang));
    pcd = 1'b1;
    cdur[0][0] = 16'h0005;
    cdur[1][0] = 16'h000A;
    cdur[2][0] = 16'h000F;
    pulses("per channel", 2, '{2, 2, 2}, '{200, 400, 600});
    pen = 6'h00;
    pulses("slot off", 2, '{0, 0, 0}, '{0, 0, 0});
    pen = 6'h01;
    pcd = 1'b0;
    place = 1'b0;
    per = 8'h03;
    skip_en = 3'b010;
    pulses("skip one of three", 3, '{3, 1, 3}, '{300, 100, 300});
    chk("fire skip", 32'h5, 32'(fire));
    act = 8'h05;
    pulses("skip clamp", 3, '{3, 3, 3}, '{300, 300, 300});
    per = 8'h02;
    act = 8'h00;
    skip_en = 3'b101;
    pulses("skip shared", 2, '{1, 2, 1}, '{100, 200, 100});
    mode = 1'b0;
    pulses("angle mode off", 1, '{0, 0, 0}, '{0, 0, 0});
    chk("fire mode off", 32'h7, 32'(fire));
    finish_test();
  end
endmodule : tb
`default_nettype wire
